/* File: hdl/poe_port_discovery_sequencer.sv */
// Per-port discovery sequencer: straps, detection, classification, modes
// Operation
// - Reset at power-up, reset pin, reset-all bit
// - Straps sampled only at reset
// - Standalone strap: detect, classify, power, drop
// - Standalone cut: 112/206/375mA by class
// - Limit 425mA classes 0-3; class 4 638/850
// - Automatic thresholds only after standalone-strap reset
// - Wait 100ms, or 2s midspan, between cycles
// - Forced current pair first, then forced voltage
// - 17k to 29k reports detect good
// - First point below 1V aborts as short
// - Detection result uses the eight codes
// - Manual: one cycle per command, then idle
// - Semi-auto polls, never powers without command
// - Classify after good detect in semi/auto, or on command in manual
// - Semi-auto high power: power only if good
// - Standalone powers port after good detection
// - Detection inhibited: auto with strap low, shutdown, disabled
// - Legacy capacitance detect optional, off at reset
// - Classify: force 18V for 12ms, measure
// - Classes 0 to 4; class 0 like 3
// - Classification inhibited: auto with strap low, shutdown, disabled
// - Mode field: 11 auto, 10 semi, 01, 00
`timescale 1ns/100ps
module poe_port_discovery_sequencer import poe_seq_pkg::*; #(
	parameter int unsigned BACKOFF_CYC = BACKOFF_CYC_DEF,
	parameter int unsigned MIDSPAN_CYC = MIDSPAN_CYC_DEF,
	parameter int unsigned CLASS_CYC   = CLASS_CYC_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic        strap_standalone,
	input  wire logic        strap_midspan,
	input  wire logic        port_disconnect,
	input  wire logic        afe_done,
	input  wire logic        afe_below_1v,
	input  wire logic [2:0]  afe_code,
	input  wire logic        afe_legacy_cap,
	input  wire logic [2:0]  afe_class,
	output logic             afe_req,
	output logic      [2:0]  afe_kind,
	output logic             class_force,
	output logic             port_power_en,
	output logic      [9:0]  overcurrent_cut_threshold,
	output logic      [9:0]  current_limit_threshold,
	output logic             startup_fault
);
	seq_state_type state_r;
	seq_state_type st_nxt;
	logic       alone_s;
	logic       mid_s;
	logic       disc_s;
	logic       srst_r;
	logic [2:0] cap_cnt_r;
	logic       ready_r;
	logic       standalone_r;
	logic       midspan_r;
	logic [1:0] mode_r;
	logic       det_en_r;
	logic       cls_en_r;
	logic       leg_en_r;
	logic       hp_en_r;
	logic       det_cmd_r;
	logic       cls_cmd_r;
	logic       on_cmd_r;
	logic       off_cmd_r;
	det_type    det_res_r;
	logic [2:0] cls_res_r;
	logic       wr;
	logic       req;
	logic       got;
	logic       inhibit;
	logic       on_req;
	logic       on_ok;
	logic       det_fin;
	det_type    det_val;
	logic       cls_fin;

	wait_tmr_if tif ();

	pin_sync u_sync_alone (.clk(clk), .rst_n(rst_n), .pin(strap_standalone), .level(alone_s));
	pin_sync u_sync_mid   (.clk(clk), .rst_n(rst_n), .pin(strap_midspan), .level(mid_s));
	pin_sync u_sync_disc  (.clk(clk), .rst_n(rst_n), .pin(port_disconnect), .level(disc_s));
	wait_timer u_timer (.clk(clk), .rst_n(rst_n), .clr(srst_r), .t(tif.tmr));

	// Legacy capacitive signature counts as good only when enabled
	function automatic det_type adj_code(input logic [2:0] code, input logic cap, input logic en);
		adj_code = (en && cap) ? DET_GOOD : det_type'(code);
	endfunction

	// State after a detection or class cycle has finished
	function automatic seq_state_type after_cycle(input logic [1:0] m, input logic good);
		if (m == MODE_MAN) begin
			after_cycle = ST_IDLE;
		end else if (m == MODE_AUTO && good) begin
			after_cycle = ST_POWERED;
		end else begin
			after_cycle = ST_BACKOFF;
		end
	endfunction

	// Class to {cut, limit}; class 0 shares the class 3 setting
	function automatic logic [19:0] class_thr(input logic [2:0] c);
		unique case (c)
			CLASS1:  class_thr = {CUT_C1, LIM_STD};
			CLASS2:  class_thr = {CUT_C2, LIM_STD};
			CLASS4:  class_thr = {CUT_C4, LIM_C4};
			default: class_thr = {CUT_C3, LIM_STD};
		endcase
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = req && wb_we_i && (wb_adr_i[7:4] == 4'h0);
	assign got = afe_req && afe_done;

	// Reserved auto code with strap low blocks detect and class, as shutdown does
	assign inhibit = (mode_r == MODE_SHUT) || (mode_r == MODE_AUTO && !standalone_r);
	assign on_req  = on_cmd_r && (mode_r == MODE_MAN || mode_r == MODE_SEMI)
		&& (state_r == ST_IDLE || state_r == ST_BACKOFF);
	assign on_ok   = on_req && !(mode_r == MODE_SEMI && hp_en_r && det_res_r != DET_GOOD);

	always_comb begin
		st_nxt  = state_r;
		det_fin = 1'b0;
		det_val = DET_UNKNOWN;
		cls_fin = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (!ready_r || inhibit) begin
					st_nxt = ST_IDLE;
				end else if (on_ok) begin
					st_nxt = ST_POWERED;
				end else if (det_en_r && (mode_r != MODE_MAN || det_cmd_r)) begin
					st_nxt = ST_FI1;
				end else if (mode_r == MODE_MAN && cls_cmd_r && cls_en_r) begin
					st_nxt = ST_CLS_FORCE;
				end
			end
			ST_FI1: begin
				if (got && afe_below_1v) begin
					det_fin = 1'b1;
					det_val = DET_SHORT;
				end else if (got) begin
					st_nxt = ST_FI2;
				end
			end
			ST_FI2: begin
				if (got && adj_code(afe_code, afe_legacy_cap, leg_en_r) == DET_GOOD) begin
					st_nxt = ST_FV1;
				end else if (got) begin
					det_fin = 1'b1;
					det_val = det_type'(afe_code);
				end
			end
			ST_FV1: begin
				if (got) begin
					st_nxt = ST_FV2;
				end
			end
			ST_FV2: begin
				if (got) begin
					det_fin = 1'b1;
					det_val = adj_code(afe_code, afe_legacy_cap, leg_en_r);
				end
			end
			ST_CLS_FORCE: begin
				if (tif.expired) begin
					st_nxt = ST_CLS_MEAS;
				end
			end
			ST_CLS_MEAS: begin
				if (got) begin
					cls_fin = 1'b1;
					st_nxt  = after_cycle(mode_r, det_res_r == DET_GOOD);
				end
			end
			ST_BACKOFF: begin
				if (on_ok) begin
					st_nxt = ST_POWERED;
				end else if (tif.expired) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_POWERED: begin
				if (disc_s || off_cmd_r || mode_r == MODE_SHUT) begin
					st_nxt = (mode_r == MODE_AUTO) ? ST_BACKOFF : ST_IDLE;
				end
			end
		endcase
		if (det_fin) begin
			if (det_val == DET_GOOD && cls_en_r && mode_r != MODE_MAN) begin
				st_nxt = ST_CLS_FORCE;
			end else begin
				st_nxt = after_cycle(mode_r, det_val == DET_GOOD);
			end
		end
		if (inhibit && state_r != ST_POWERED) begin
			st_nxt = ST_IDLE;
		end
	end

	// Timer restarts on entry to the class window or the back-off wait
	assign tif.start = (st_nxt != state_r)
		&& (st_nxt == ST_BACKOFF || st_nxt == ST_CLS_FORCE);
	assign tif.load = (st_nxt == ST_CLS_FORCE) ? TMR_W'(CLASS_CYC)
		: midspan_r ? TMR_W'(MIDSPAN_CYC) : TMR_W'(BACKOFF_CYC);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r       <= ST_IDLE;
			afe_req       <= 1'b0;
			afe_kind      <= KIND_FI1;
			class_force   <= 1'b0;
			port_power_en <= 1'b0;
		end else if (srst_r) begin
			state_r       <= ST_IDLE;
			afe_req       <= 1'b0;
			afe_kind      <= KIND_FI1;
			class_force   <= 1'b0;
			port_power_en <= 1'b0;
		end else begin
			state_r       <= st_nxt;
			afe_req       <= (st_nxt inside {ST_FI1, ST_FI2, ST_FV1, ST_FV2, ST_CLS_MEAS})
				&& !got;
			afe_kind      <= (st_nxt == ST_FI2) ? KIND_FI2 : (st_nxt == ST_FV1) ? KIND_FV1
				: (st_nxt == ST_FV2) ? KIND_FV2 : (st_nxt == ST_CLS_MEAS) ? KIND_CLASS
				: KIND_FI1;
			class_force   <= (st_nxt == ST_CLS_FORCE) || (st_nxt == ST_CLS_MEAS);
			port_power_en <= (st_nxt == ST_POWERED);
		end
	end

	// Straps are caught once the synchronisers have settled after a reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_cnt_r    <= 3'h0;
			ready_r      <= 1'b0;
			standalone_r <= 1'b0;
			midspan_r    <= 1'b0;
		end else if (srst_r) begin
			cap_cnt_r <= 3'h0;
			ready_r   <= 1'b0;
		end else if (!ready_r) begin
			cap_cnt_r <= cap_cnt_r + 3'h1;
			if (cap_cnt_r == CAP_WAIT) begin
				ready_r      <= 1'b1;
				standalone_r <= alone_s;
				midspan_r    <= mid_s;
			end
		end
	end

	// Control register, command pulses and the software reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r    <= MODE_SHUT;
			det_en_r  <= 1'b0;
			cls_en_r  <= 1'b0;
			leg_en_r  <= 1'b0;
			hp_en_r   <= 1'b0;
			det_cmd_r <= 1'b0;
			cls_cmd_r <= 1'b0;
			on_cmd_r  <= 1'b0;
			off_cmd_r <= 1'b0;
			srst_r    <= 1'b0;
		end else begin
			det_cmd_r <= 1'b0;
			cls_cmd_r <= 1'b0;
			on_cmd_r  <= 1'b0;
			off_cmd_r <= 1'b0;
			srst_r    <= wr && wb_adr_i[3:2] == REG_CTRL[3:2] && wb_sel_i[3]
				&& wb_dat_i[CTL_RST_ALL] && !srst_r;
			if (srst_r) begin
				mode_r   <= MODE_SHUT;
				det_en_r <= 1'b0;
				cls_en_r <= 1'b0;
				leg_en_r <= 1'b0;
				hp_en_r  <= 1'b0;
			end else if (!ready_r && cap_cnt_r == CAP_WAIT) begin
				mode_r   <= alone_s ? MODE_AUTO : MODE_SHUT;
				det_en_r <= alone_s;
				cls_en_r <= alone_s;
			end else if (wr && wb_adr_i[3:2] == REG_CTRL[3:2]) begin
				if (wb_sel_i[0]) begin
					mode_r   <= wb_dat_i[CTL_MODE_LSB +: 2];
					det_en_r <= wb_dat_i[CTL_DET_EN];
					cls_en_r <= wb_dat_i[CTL_CLS_EN];
					leg_en_r <= wb_dat_i[CTL_LEG_EN];
					hp_en_r  <= wb_dat_i[CTL_HP_EN];
				end
				if (wb_sel_i[1]) begin
					det_cmd_r <= wb_dat_i[CTL_DET_CMD];
					cls_cmd_r <= wb_dat_i[CTL_CLS_CMD];
					on_cmd_r  <= wb_dat_i[CTL_ON_CMD];
					off_cmd_r <= wb_dat_i[CTL_OFF_CMD];
				end
			end
		end
	end

	// Results and thresholds; a fault set beats a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			det_res_r                 <= DET_UNKNOWN;
			cls_res_r                 <= 3'h0;
			startup_fault             <= 1'b0;
			overcurrent_cut_threshold <= CUT_C3;
			current_limit_threshold   <= LIM_STD;
		end else if (srst_r) begin
			det_res_r                 <= DET_UNKNOWN;
			cls_res_r                 <= 3'h0;
			startup_fault             <= 1'b0;
			overcurrent_cut_threshold <= CUT_C3;
			current_limit_threshold   <= LIM_STD;
		end else begin
			if (det_fin) begin
				det_res_r <= det_val;
			end
			if (cls_fin) begin
				cls_res_r <= afe_class;
			end
			if (cls_fin && mode_r == MODE_AUTO && standalone_r) begin
				{overcurrent_cut_threshold, current_limit_threshold} <= class_thr(afe_class);
			end
			if (on_req && !on_ok) begin
				startup_fault <= 1'b1;
			end else if (wr && wb_adr_i[3:2] == REG_STATUS[3:2] && wb_sel_i[1]
				&& wb_dat_i[ST_FAULT]) begin
				startup_fault <= 1'b0;
			end
		end
	end

	// Wishbone slave: one wait state, unmapped reads return zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h0;
			if (req && !wb_we_i && wb_adr_i[7:4] == 4'h0) begin
				unique case (wb_adr_i[3:2])
					REG_CTRL[3:2]: begin
						wb_dat_o[CTL_MODE_LSB +: 2] <= mode_r;
						wb_dat_o[CTL_DET_EN]        <= det_en_r;
						wb_dat_o[CTL_CLS_EN]        <= cls_en_r;
						wb_dat_o[CTL_LEG_EN]        <= leg_en_r;
						wb_dat_o[CTL_HP_EN]         <= hp_en_r;
					end
					REG_STATUS[3:2]: begin
						wb_dat_o[ST_DET_LSB +: 3] <= det_res_r;
						wb_dat_o[ST_CLS_LSB +: 3] <= cls_res_r;
						wb_dat_o[ST_PWR]          <= port_power_en;
						wb_dat_o[ST_FAULT]        <= startup_fault;
						wb_dat_o[ST_ALONE]        <= standalone_r;
						wb_dat_o[ST_MIDSPAN]      <= midspan_r;
						wb_dat_o[ST_READY]        <= ready_r;
					end
					REG_THRESH[3:2]: begin
						wb_dat_o[TH_CUT_LSB +: 10] <= overcurrent_cut_threshold;
						wb_dat_o[TH_LIM_LSB +: 10] <= current_limit_threshold;
					end
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	strap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		ready_r && !srst_r |=> $stable(standalone_r) && $stable(midspan_r))
		else $error("strap latch changed outside reset");
	short_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_FI1 && got && afe_below_1v && !srst_r
		|=> det_res_r == DET_SHORT && state_r != ST_FI2)
		else $error("low first point did not abort as short");
	volt_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_FI2 && got && !(leg_en_r && afe_legacy_cap)
		&& afe_code != DET_GOOD |=> state_r != ST_FV1)
		else $error("forced voltage ran after bad forced current");
	manual_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_r == MODE_MAN && det_fin && det_val != DET_GOOD && !srst_r
		|=> state_r == ST_IDLE)
		else $error("manual detect did not return to idle");
	semi_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(port_power_en) && mode_r == MODE_SEMI |-> $past(on_cmd_r))
		else $error("semi-auto powered without a command");
	start_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
		on_req && mode_r == MODE_SEMI && hp_en_r && det_res_r != DET_GOOD && !srst_r
		|=> startup_fault && !port_power_en ##1 !port_power_en)
		else $error("bad detect result did not give a startup fault");
	class_thr_a: assert property (@(posedge clk) disable iff (!rst_n)
		cls_fin && !srst_r && mode_r == MODE_AUTO && standalone_r && afe_class == CLASS4
		|=> overcurrent_cut_threshold == CUT_C4 && current_limit_threshold == LIM_C4)
		else $error("class 4 thresholds not applied");
	det_inhibit_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == ST_IDLE && (inhibit || !det_en_r) |=> state_r != ST_FI1)
		else $error("detection ran while inhibited");
	class_window_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(class_force) |-> class_force [*4] ##0 !afe_req)
		else $error("class force window cut short");
	backoff_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		tif.start && st_nxt == ST_BACKOFF |-> tif.load == (midspan_r
		? TMR_W'(MIDSPAN_CYC) : TMR_W'(BACKOFF_CYC)))
		else $error("wrong back-off wait loaded");
	result_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!det_fin && !srst_r |=> $stable(det_res_r))
		else $error("detect result changed without a finished cycle");

	powered_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(port_power_en));
	short_c: cover property (@(posedge clk) disable iff (!rst_n) det_fin && det_val == DET_SHORT);
	class_c: cover property (@(posedge clk) disable iff (!rst_n) cls_fin);
	fault_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(startup_fault));
endmodule // poe_port_discovery_sequencer

/* File: hdl/poe_seq_pkg.sv */
// Shared constants, field layout and types of the port discovery sequencer
package poe_seq_pkg;
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned BACKOFF_MS      = 100;
	localparam int unsigned MIDSPAN_MS      = 2000;
	localparam int unsigned CLASS_MS        = 12;
	localparam int unsigned BACKOFF_CYC_DEF = BACKOFF_MS * CYC_PER_MS;
	localparam int unsigned MIDSPAN_CYC_DEF = MIDSPAN_MS * CYC_PER_MS;
	localparam int unsigned CLASS_CYC_DEF   = CLASS_MS * CYC_PER_MS;
	localparam int unsigned TMR_W           = 28;
	localparam logic [2:0]  CAP_WAIT        = 3'h5;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_THRESH = 8'h08;

	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_DET_EN   = 2;
	localparam int CTL_CLS_EN   = 3;
	localparam int CTL_LEG_EN   = 4;
	localparam int CTL_HP_EN    = 5;
	localparam int CTL_DET_CMD  = 8;
	localparam int CTL_CLS_CMD  = 9;
	localparam int CTL_ON_CMD   = 10;
	localparam int CTL_OFF_CMD  = 11;
	localparam int CTL_RST_ALL  = 31;
	localparam int ST_DET_LSB   = 0;
	localparam int ST_CLS_LSB   = 4;
	localparam int ST_PWR       = 8;
	localparam int ST_FAULT     = 9;
	localparam int ST_ALONE     = 10;
	localparam int ST_MIDSPAN   = 11;
	localparam int ST_READY     = 12;
	localparam int TH_CUT_LSB   = 0;
	localparam int TH_LIM_LSB   = 16;

	localparam logic [1:0] MODE_SHUT = 2'h0;
	localparam logic [1:0] MODE_MAN  = 2'h1;
	localparam logic [1:0] MODE_SEMI = 2'h2;
	localparam logic [1:0] MODE_AUTO = 2'h3;

	localparam logic [2:0] KIND_FI1   = 3'h0;
	localparam logic [2:0] KIND_FI2   = 3'h1;
	localparam logic [2:0] KIND_FV1   = 3'h2;
	localparam logic [2:0] KIND_FV2   = 3'h3;
	localparam logic [2:0] KIND_CLASS = 3'h4;

	localparam logic [2:0] CLASS1 = 3'h1;
	localparam logic [2:0] CLASS2 = 3'h2;
	localparam logic [2:0] CLASS4 = 3'h4;

	localparam logic [9:0] CUT_C1  = 10'd112;
	localparam logic [9:0] CUT_C2  = 10'd206;
	localparam logic [9:0] CUT_C3  = 10'd375;
	localparam logic [9:0] CUT_C4  = 10'd638;
	localparam logic [9:0] LIM_STD = 10'd425;
	localparam logic [9:0] LIM_C4  = 10'd850;

	typedef enum logic [2:0] {
		DET_UNKNOWN, DET_SHORT, DET_CAP_HIGH, DET_R_LOW,
		DET_GOOD, DET_R_HIGH, DET_OPEN, DET_V_OUT
	} det_type;

	typedef enum logic [3:0] {
		ST_IDLE, ST_FI1, ST_FI2, ST_FV1, ST_FV2,
		ST_CLS_FORCE, ST_CLS_MEAS, ST_BACKOFF, ST_POWERED
	} seq_state_type;
endpackage

/* File: hdl/wait_tmr_if.sv */
// Start and expiry signals between the sequencer and its wait timer
`timescale 1ns/100ps
interface wait_tmr_if import poe_seq_pkg::*; ();
	logic             start;
	logic [TMR_W-1:0] load;
	logic             expired;
	modport ctl (output start, output load, input expired);
	modport tmr (input start, input load, output expired);
endinterface

/* File: hdl/pin_sync.sv */
// Three-stage synchroniser that takes a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			s3_r  <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level <= s3_r;
			end
		end
	end
endmodule // pin_sync

/* File: hdl/wait_timer.sv */
// Down counter that pulses expired once the loaded count has elapsed
`timescale 1ns/100ps
module wait_timer import poe_seq_pkg::*; (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clr,
	wait_tmr_if.tmr   t
);
	logic [TMR_W-1:0] count_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r   <= '0;
			t.expired <= 1'b0;
		end else if (clr) begin
			count_r   <= '0;
			t.expired <= 1'b0;
		end else if (t.start) begin
			count_r   <= t.load;
			t.expired <= 1'b0;
		end else begin
			if (count_r != '0) begin
				count_r <= count_r - 1'b1;
			end
			t.expired <= (count_r == TMR_W'(1));
		end
	end
endmodule // wait_timer

/* File: tb/pd_model.sv */
// Powered device model that answers the sequencer's measurement requests
`timescale 1ns/100ps
module pd_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       req,
	input  wire logic       below,
	input  wire logic [2:0] code,
	input  wire logic       cap,
	input  wire logic [2:0] cls,
	input  wire logic [3:0] lat,
	output logic            done,
	output logic            below_1v,
	output logic      [2:0] afe_code,
	output logic            legacy_cap,
	output logic      [2:0] afe_class
);
	logic [3:0] cnt_r;

	// Answer after lat cycles so both prompt and slow replies occur
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 4'h0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (req && !done) begin
				if (cnt_r == lat) begin
					done  <= 1'b1;
					cnt_r <= 4'h0;
				end else begin
					cnt_r <= cnt_r + 4'h1;
				end
			end
		end
	end

	// Results only hold with done; otherwise show the inverse
	assign below_1v   = done ? below : ~below;
	assign afe_code   = done ? code : ~code;
	assign legacy_cap = done ? cap : ~cap;
	assign afe_class  = done ? cls : ~cls;
endmodule // pd_model

/* File: tb/poe_port_discovery_sequencer_tb_top.sv */
// Testbench of the port discovery sequencer
`timescale 1ns/100ps
module poe_port_discovery_sequencer_tb_top import poe_seq_pkg::*;;
	localparam int BK = 50;
	localparam int MS = 200;
	typedef struct {logic [2:0] c; logic [9:0] cut; logic [9:0] lim;} row_type;
	logic        clk, rst_n, cyc, stb, we, ack, s_alone, s_mid, disc;
	logic        below, cap, done, b1v, lcap, req, frc, pwr, fault;
	logic [3:0]  sel, lat;
	logic [7:0]  adr;
	logic [31:0] wd, rd, q;
	logic [2:0]  code, cls, acode, acls, kind;
	logic [9:0]  cut, lim;
	int          error_cnt, cmp_count, gap;
	row_type     rows [5] = '{'{3'h0, CUT_C3, LIM_STD}, '{CLASS1, CUT_C1, LIM_STD},
		'{CLASS2, CUT_C2, LIM_STD}, '{3'h3, CUT_C3, LIM_STD}, '{CLASS4, CUT_C4, LIM_C4}};

	poe_port_discovery_sequencer #(.BACKOFF_CYC(BK), .MIDSPAN_CYC(MS), .CLASS_CYC(20)) u_dut (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(rd),
		.strap_standalone(s_alone), .strap_midspan(s_mid), .port_disconnect(disc),
		.afe_done(done), .afe_below_1v(b1v), .afe_code(acode), .afe_legacy_cap(lcap),
		.afe_class(acls), .afe_req(req), .afe_kind(kind), .class_force(frc),
		.port_power_en(pwr), .overcurrent_cut_threshold(cut),
		.current_limit_threshold(lim), .startup_fault(fault));

	pd_model u_pd (.clk(clk), .rst_n(rst_n), .req(req), .below(below), .code(code),
		.cap(cap), .cls(cls), .lat(lat), .done(done), .below_1v(b1v), .afe_code(acode),
		.legacy_cap(lcap), .afe_class(acls));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic w);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= s;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			error_cnt++;
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic do_reset(input logic sa, input logic sm);
		s_alone <= sa;
		s_mid <= sm;
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask

	task automatic give_verdict;
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		int lo;
		{cyc, stb, we, disc, below, cap, s_mid, rst_n} = '0;
		{sel, adr, wd, cls, lat} = '0;
		code = DET_GOOD;
		s_alone = 1'b1;
		foreach (rows[i]) begin
			cls <= rows[i].c;
			lat <= 4'(i);
			do_reset(1'b1, 1'b0);
			for (int n = 0; n < 2000 && frc !== 1'b1; n++) @(posedge clk);
			for (gap = 0; gap < 100 && frc === 1'b1; gap++) @(posedge clk);
			chk(32'(gap >= 20 && gap <= 40), 32'h1);
			for (int n = 0; n < 2000 && pwr !== 1'b1; n++) @(posedge clk);
			chk(pwr, 1'b1);
			bus(REG_THRESH, 32'h0, 4'hf, 1'b0);
			chk(q, {6'h0, rows[i].lim, 6'h0, rows[i].cut});
			bus(REG_STATUS, 32'h0, 4'hf, 1'b0);
			chk(q[6:0], {rows[i].c, 1'b0, DET_GOOD});
		end
		disc <= 1'b1;
		repeat (8) @(posedge clk);
		chk(pwr, 1'b0);
		disc <= 1'b0;
		below <= 1'b1;
		lat <= 4'h2;
		for (int m = 0; m < 2; m++) begin
			lo = m ? MS : BK;
			do_reset(1'b1, m[0]);
			for (int n = 0; n < 400 && req !== 1'b1; n++) @(posedge clk);
			chk(kind, KIND_FI1);
			for (int n = 0; n < 400 && req !== 1'b0; n++) @(posedge clk);
			for (gap = 0; gap < 400 && req !== 1'b1; gap++) @(posedge clk);
			chk(32'(gap >= lo && gap <= lo + 10), 32'h1);
			bus(REG_STATUS, 32'h0, 4'hf, 1'b0);
			chk({q[8], q[2:0]}, {1'b0, DET_SHORT});
		end
		below <= 1'b0;
		code <= DET_R_HIGH;
		cap <= 1'b1;
		do_reset(1'b0, 1'b0);
		s_alone <= 1'b1;
		repeat (20) @(posedge clk);
		chk(req, 1'b0);
		bus(REG_STATUS, 32'h0, 4'hf, 1'b0);
		chk({q[12:10], q[2:0]}, {3'h4, DET_UNKNOWN});
		bus(REG_THRESH, 32'h0, 4'hf, 1'b0);
		chk(q, {6'h0, LIM_STD, 6'h0, CUT_C3});
		bus(REG_CTRL, 32'h25, 4'h1, 1'b1);
		bus(REG_CTRL, 32'h100, 4'h2, 1'b1);
		repeat (30) @(posedge clk);
		chk(req, 1'b0);
		bus(REG_STATUS, 32'h0, 4'hf, 1'b0);
		chk(q[2:0], DET_R_HIGH);
		bus(REG_CTRL, 32'h22, 4'h1, 1'b1);
		bus(REG_CTRL, 32'h400, 4'h2, 1'b1);
		repeat (4) @(posedge clk);
		chk({fault, pwr}, 2'h2);
		bus(REG_STATUS, 32'h200, 4'h2, 1'b1);
		chk(fault, 1'b0);
		bus(REG_CTRL, 32'h21, 4'h1, 1'b1);
		bus(REG_CTRL, 32'h400, 4'h2, 1'b1);
		repeat (4) @(posedge clk);
		chk(pwr, 1'b1);
		bus(REG_CTRL, 32'h800, 4'h2, 1'b1);
		bus(REG_CTRL, 32'h35, 4'h1, 1'b1);
		bus(REG_CTRL, 32'h100, 4'h2, 1'b1);
		repeat (30) @(posedge clk);
		bus(REG_STATUS, 32'h0, 4'hf, 1'b0);
		chk({q[8], q[2:0]}, {1'b0, DET_GOOD});
		cap <= 1'b0;
		code <= DET_GOOD;
		bus(REG_CTRL, 32'h26, 4'h1, 1'b1);
		repeat (150) @(posedge clk);
		chk(pwr, 1'b0);
		bus(REG_CTRL, 32'h0c, 4'h1, 1'b1);
		repeat (60) @(posedge clk);
		chk(req, 1'b0);
		bus(REG_CTRL, 32'h8000_0000, 4'h8, 1'b1);
		repeat (12) @(posedge clk);
		bus(REG_STATUS, 32'h0, 4'hf, 1'b0);
		chk(q[10], 1'b1);
		give_verdict();
	end
endmodule // poe_port_discovery_sequencer_tb_top
